// ==== logic/pds_pwm_bridge.sv ====
// Enhanced PWM output stage: dead band, polarity, auto-shutdown, registers
`timescale 1ns/1ps
module pds_pwm_bridge
	import pds_pkg::*;
#(
	parameter bit ENHANCED = 1'b1
) (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	// Register port
	input  wire logic [1:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// Period generator
	input  wire logic       pwm_sched_i,
	input  wire logic       period_start_i,
	// Shutdown sources
	input  wire logic       fault_in_n_i,
	input  wire logic       cmp1_i,
	input  wire logic       cmp2_i,
	// Bridge pins
	output pds_quad_t       bridge_o,
	output pds_quad_t       bridge_oe_o,
	output logic            period_timer_flag_o
);

	localparam logic [7:0] CFG_WMASK = ENHANCED ? 8'hff : 8'h80;
	localparam logic [6:0] ASD_WMASK = ENHANCED ? 7'h7f : 7'h7c;

	logic [7:0]                 cfg_q;
	logic [6:0]                 asd_q;
	logic [7:0]                 mode_q;
	logic                       ptf_q;
	logic [7:0]                 rdata_q;
	pds_quad_t                  pin_q;
	pds_quad_t                  pin_oe_q;
	pds_quad_t                  act_c;
	pds_quad_t                  sd_lvl_c;
	pds_quad_t                  sd_oe_c;
	logic [1:0]                 sched_c;
	logic [1:0]                 db_act;
	logic [2:0]                 src_c;
	logic [2:0]                 hit_c;
	logic                       mode_en;
	pds_outcfg_t                outcfg;
	logic                       db_en;
	logic                       cause_c;
	logic                       status;
	logic                       run;
	logic                       force_c;
	logic                       wr_cfg;
	logic                       wr_asd;
	logic                       wr_mode;
	logic                       wr_stat;
	logic [PDS_CFG_COUNT_W-1:0] count_c;
	logic [1:0]                 ac_drv;
	logic [1:0]                 bd_drv;

	// Strobe aimed at one register offset
	function automatic logic reg_hit(input logic strobe, input logic [1:0] a,
		input logic [1:0] ofs);
		reg_hit = strobe && (a == ofs);
	endfunction

	assign wr_cfg  = reg_hit(wr_i, addr_i, PDS_OFS_CFG);
	assign wr_asd  = reg_hit(wr_i, addr_i, PDS_OFS_ASD);
	assign wr_mode = reg_hit(wr_i, addr_i, PDS_OFS_MODE);
	assign wr_stat = reg_hit(wr_i, addr_i, PDS_OFS_STAT);

	// Registers
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_q <= PDS_CFG_RESET;
		end else if (wr_cfg) begin
			cfg_q <= wdata_i & CFG_WMASK;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			asd_q <= PDS_ASD_RESET[6:0];
		end else if (wr_asd) begin
			asd_q <= wdata_i[6:0] & ASD_WMASK;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_q <= PDS_MODE_RESET;
		end else if (wr_mode) begin
			mode_q <= wdata_i & PDS_MODE_MASK;
		end
	end

	// Period start outranks a clearing write so no completion is lost
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ptf_q <= PDS_PTF_RESET;
		end else if (period_start_i) begin
			ptf_q <= 1'b1;
		end else if (wr_stat) begin
			ptf_q <= wdata_i[PDS_STAT_PTF_BIT];
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_q <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				PDS_OFS_CFG:  rdata_q <= cfg_q;
				PDS_OFS_ASD:  rdata_q <= {status, asd_q};
				PDS_OFS_MODE: rdata_q <= mode_q;
				PDS_OFS_STAT: rdata_q <= {7'h00, ptf_q};
				default:      rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata_o             = rdata_q;
	assign period_timer_flag_o = ptf_q;

	// Shutdown cause
	assign mode_en = mode_q[PDS_MODE_EN_BIT];
	assign outcfg  = pds_outcfg_t'(mode_q[PDS_MODE_OUTCFG_LSB +: 2]);
	assign src_c   = asd_q[PDS_ASD_SRC_LSB +: 3];
	assign hit_c[PDS_SRC_CMP1_BIT]  = cmp1_i;
	assign hit_c[PDS_SRC_CMP2_BIT]  = cmp2_i;
	assign hit_c[PDS_SRC_FAULT_BIT] = !fault_in_n_i;
	assign cause_c = mode_en && |(hit_c & src_c);

	pds_shutdown_ctl u_sd (
		.clock_i       (clock_i),
		.nrst_i        (nrst_i),
		.cause_i       (cause_c),
		.restart_en_i  (cfg_q[PDS_CFG_RESTART_BIT]),
		.period_start_i(period_start_i),
		.sw_wr_i       (wr_asd),
		.sw_val_i      (wdata_i[PDS_ASD_STATUS_BIT]),
		.status_o      (status),
		.run_o         (run)
	);

	// Live cause bypasses the flops so pins drop without a clock edge
	assign force_c = mode_en && (!run || cause_c);

	// Dead band on the true and complement schedules
	assign count_c    = cfg_q[PDS_CFG_COUNT_W-1:0];
	assign db_en      = ENHANCED && mode_en && (outcfg == PDS_OUT_HALF);
	assign sched_c[0] = pwm_sched_i;
	assign sched_c[1] = !pwm_sched_i;

	for (genvar g = 0; g < 2; g++) begin : g_db
		pds_deadband #(
			.CNT_W(PDS_CFG_COUNT_W)
		) u_db (
			.clock_i(clock_i),
			.nrst_i (nrst_i),
			.en_i   (db_en),
			.count_i(count_c),
			.sched_i(sched_c[g]),
			.act_o  (db_act[g])
		);
	end

	// Logical active levels per output mode
	always_comb begin
		act_c = '0;
		case (outcfg)
			PDS_OUT_SINGLE: begin
				act_c.bridge_out_a = db_act[0];
			end
			PDS_OUT_HALF: begin
				act_c.bridge_out_a = db_act[0];
				act_c.bridge_out_b = db_act[1];
			end
			PDS_OUT_FULL_FWD: begin
				act_c.bridge_out_a = 1'b1;
				act_c.bridge_out_d = db_act[0];
			end
			PDS_OUT_FULL_REV: begin
				act_c.bridge_out_c = 1'b1;
				act_c.bridge_out_b = db_act[0];
			end
			default: act_c = '0;
		endcase
	end

	// Polarity before the shutdown mux, so shutdown codes are pin levels
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_q    <= '0;
			pin_oe_q <= '0;
		end else begin
			pin_q.bridge_out_a <= act_c.bridge_out_a ^ mode_q[PDS_MODE_POL_AC_BIT];
			pin_q.bridge_out_c <= act_c.bridge_out_c ^ mode_q[PDS_MODE_POL_AC_BIT];
			pin_q.bridge_out_b <= act_c.bridge_out_b ^ mode_q[PDS_MODE_POL_BD_BIT];
			pin_q.bridge_out_d <= act_c.bridge_out_d ^ mode_q[PDS_MODE_POL_BD_BIT];
			pin_oe_q           <= {4{mode_en}};
		end
	end

	assign ac_drv = pds_sd_drive(asd_q[PDS_ASD_AC_LSB +: 2]);
	assign bd_drv = pds_sd_drive(asd_q[PDS_ASD_BD_LSB +: 2]);
	assign sd_lvl_c = '{bridge_out_a: ac_drv[0], bridge_out_b: bd_drv[0],
		bridge_out_c: ac_drv[0], bridge_out_d: bd_drv[0]};
	assign sd_oe_c  = '{bridge_out_a: ac_drv[1], bridge_out_b: bd_drv[1],
		bridge_out_c: ac_drv[1], bridge_out_d: bd_drv[1]};

	assign bridge_o    = force_c ? sd_lvl_c : pin_q;
	assign bridge_oe_o = force_c ? sd_oe_c : pin_oe_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	a_fault_trips_pins: assert property (
		(mode_en && src_c[PDS_SRC_FAULT_BIT] && !fault_in_n_i) |-> force_c)
		else $error("low fault did not force shutdown");
	a_src_disabled: assert property (
		(src_c == 3'h0 && run) |-> !force_c)
		else $error("shutdown with no source selected");
	a_ac_level: assert property (
		(force_c && asd_q[PDS_ASD_AC_LSB +: 2] == 2'h1) |->
		bridge_o.bridge_out_a && bridge_o.bridge_out_c && bridge_oe_o.bridge_out_a)
		else $error("A/C pins not driven high in shutdown");
	a_bd_release: assert property (
		(force_c && asd_q[PDS_ASD_BD_LSB + 1]) |->
		!bridge_oe_o.bridge_out_b && !bridge_oe_o.bridge_out_d)
		else $error("B/D pins still driven in shutdown");
	a_hold_period: assert property (
		(mode_en && status && period_start_i && !cause_c) |=> force_c)
		else $error("outputs released in a shutdown period");
	a_auto_clear: assert property (
		(status && cfg_q[PDS_CFG_RESTART_BIT] && !cause_c && !wr_asd) |=> !status)
		else $error("auto restart did not clear status");
	a_sw_force: assert property (
		(wr_asd && wdata_i[PDS_ASD_STATUS_BIT]) |=> status ##0 (!mode_en || force_c))
		else $error("write of one did not force shutdown");
	a_full_no_db: assert property (
		(outcfg == PDS_OUT_FULL_FWD && $stable(outcfg)) |->
		act_c.bridge_out_d == $past(pwm_sched_i))
		else $error("full-bridge output was delayed");
	a_polarity_path: assert property (
		(!force_c && $stable(mode_q)) |->
		bridge_o.bridge_out_b == $past(act_c.bridge_out_b ^ mode_q[PDS_MODE_POL_BD_BIT]))
		else $error("B pin not polarity of delayed level");
	a_flag_period: assert property (
		period_start_i |=> period_timer_flag_o)
		else $error("period flag not set");
	a_flag_write: assert property (
		(wr_stat && !period_start_i) |=>
		period_timer_flag_o == $past(wdata_i[PDS_STAT_PTF_BIT]))
		else $error("period flag write not stored");

	a_cmp1_trips: assert property (
		(mode_en && src_c[PDS_SRC_CMP1_BIT] && cmp1_i) |-> force_c)
		else $error("comparator 1 did not force shutdown");
	a_cmp2_trips: assert property (
		(mode_en && src_c[PDS_SRC_CMP2_BIT] && cmp2_i) |-> force_c)
		else $error("comparator 2 did not force shutdown");
	a_cause_forces: assert property (
		cause_c |-> force_c)
		else $error("live cause did not force pins");
	a_status_forces: assert property (
		(mode_en && status) |-> force_c)
		else $error("status set but pins not held");
	a_disabled_quiet: assert property (
		!mode_en |-> !force_c)
		else $error("disabled module forced its pins");
	a_disabled_oe: assert property (
		(!mode_en && $stable(mode_en)) |->
		bridge_oe_o == '0)
		else $error("disabled module drives its pins");
	a_unselected_quiet: assert property (
		(mode_en && !src_c[PDS_SRC_FAULT_BIT] && !cmp1_i && !cmp2_i) |-> !cause_c)
		else $error("cause from an unselected source");
	a_fault_high_idle: assert property (
		(mode_en && src_c == 3'h4 && fault_in_n_i) |-> !cause_c)
		else $error("high fault pin caused shutdown");

	a_ac_low: assert property (
		(force_c && asd_q[PDS_ASD_AC_LSB +: 2] == 2'h0) |->
		!bridge_o.bridge_out_a && !bridge_o.bridge_out_c && bridge_oe_o.bridge_out_c)
		else $error("A/C pins not driven low in shutdown");
	a_ac_release: assert property (
		(force_c && asd_q[PDS_ASD_AC_LSB + 1]) |->
		!bridge_oe_o.bridge_out_a && !bridge_oe_o.bridge_out_c)
		else $error("A/C pins still driven in shutdown");
	a_bd_high: assert property (
		(force_c && asd_q[PDS_ASD_BD_LSB +: 2] == 2'h1) |->
		bridge_o.bridge_out_b && bridge_o.bridge_out_d && bridge_oe_o.bridge_out_d)
		else $error("B/D pins not driven high in shutdown");
	a_bd_low: assert property (
		(force_c && asd_q[PDS_ASD_BD_LSB +: 2] == 2'h0) |->
		!bridge_o.bridge_out_b && !bridge_o.bridge_out_d && bridge_oe_o.bridge_out_b)
		else $error("B/D pins not driven low in shutdown");

	// Both switches of a leg never scheduled on together
	a_no_overlap: assert property (
		db_en |-> !(db_act[0] && db_act[1]))
		else $error("true and complement active together");
	a_polarity_ac: assert property (
		(!force_c && $stable(mode_q)) |->
		bridge_o.bridge_out_a == $past(act_c.bridge_out_a ^ mode_q[PDS_MODE_POL_AC_BIT]))
		else $error("A pin not polarity of delayed level");

	c_fault_trip:   cover property (mode_en && $rose(status) && !fault_in_n_i);
	c_auto_restart: cover property ($fell(status) ##[1:100] $rose(run));
	c_half_delay:   cover property (db_en && count_c > 7'h02 && $rose(pwm_sched_i));
	c_manual_rst:   cover property (!cfg_q[PDS_CFG_RESTART_BIT] && $fell(status));
	c_sw_trip:      cover property (wr_asd && wdata_i[PDS_ASD_STATUS_BIT] && !cause_c);

endmodule // pds_pwm_bridge

// ==== logic/pds_pkg.sv ====
// Constants, types and shared decode for the dead-band and auto-shutdown block
package pds_pkg;

	// Register offsets on the plain register port
	localparam logic [1:0] PDS_OFS_CFG  = 2'h0;
	localparam logic [1:0] PDS_OFS_ASD  = 2'h1;
	localparam logic [1:0] PDS_OFS_MODE = 2'h2;
	localparam logic [1:0] PDS_OFS_STAT = 2'h3;

	// Field positions
	localparam int PDS_CFG_RESTART_BIT = 7;
	localparam int PDS_CFG_COUNT_W     = 7;
	localparam int PDS_ASD_STATUS_BIT  = 7;
	localparam int PDS_ASD_SRC_LSB     = 4;
	localparam int PDS_ASD_AC_LSB      = 2;
	localparam int PDS_ASD_BD_LSB      = 0;
	localparam int PDS_MODE_EN_BIT     = 4;
	localparam int PDS_MODE_OUTCFG_LSB = 2;
	localparam int PDS_MODE_POL_AC_BIT = 1;
	localparam int PDS_MODE_POL_BD_BIT = 0;
	localparam int PDS_STAT_PTF_BIT    = 0;

	// Bits inside the shutdown source field
	localparam int PDS_SRC_CMP1_BIT  = 0;
	localparam int PDS_SRC_CMP2_BIT  = 1;
	localparam int PDS_SRC_FAULT_BIT = 2;

	// Reset values
	localparam logic [7:0] PDS_CFG_RESET  = 8'h00;
	localparam logic [7:0] PDS_ASD_RESET  = 8'h00;
	localparam logic [7:0] PDS_MODE_RESET = 8'h00;
	localparam logic       PDS_PTF_RESET  = 1'b0;

	// Writable bits of the mode register
	localparam logic [7:0] PDS_MODE_MASK = 8'h1f;

	typedef enum logic [1:0] {
		PDS_OUT_SINGLE   = 2'h0,
		PDS_OUT_HALF     = 2'h1,
		PDS_OUT_FULL_FWD = 2'h2,
		PDS_OUT_FULL_REV = 2'h3
	} pds_outcfg_t;

	typedef enum logic [2:0] {
		PDS_SD_RUN     = 3'h1,
		PDS_SD_TRIPPED = 3'h2,
		PDS_SD_WAIT    = 3'h4
	} pds_sd_state_t;

	typedef struct packed {
		logic bridge_out_a;
		logic bridge_out_b;
		logic bridge_out_c;
		logic bridge_out_d;
	} pds_quad_t;

	// Shutdown state code to {enable, level}: 00 low, 01 high, 1x released
	function automatic logic [1:0] pds_sd_drive(input logic [1:0] code);
		pds_sd_drive = code[1] ? 2'h0 : {1'b1, code[0]};
	endfunction

endpackage : pds_pkg

// ==== logic/pds_deadband.sv ====
// Dead-band delay on the inactive-to-active edge of one scheduled output
`timescale 1ns/1ps
module pds_deadband
	import pds_pkg::*;
#(
	parameter int CNT_W = 7
) (
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             nrst_i,
	// Control
	input  wire logic             en_i,
	input  wire logic [CNT_W-1:0] count_i,
	// Scheduled and delayed level
	input  wire logic             sched_i,
	output logic                  act_o
);

	logic [CNT_W-1:0] cnt_q;
	logic             act_q;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			act_q <= 1'b0;
			cnt_q <= '0;
		end else if (!en_i) begin
			act_q <= sched_i;
			cnt_q <= '0;
		end else if (!sched_i) begin
			act_q <= 1'b0;
			cnt_q <= '0;
		end else if (!act_q) begin
			if (cnt_q >= count_i) begin
				act_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	assign act_o = act_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	a_db_hold_off: assert property (
		(en_i && sched_i && !act_q && cnt_q < count_i) |=> !act_q)
		else $error("delayed output went active before count expired");
	a_db_fall_fast: assert property (
		(en_i && !sched_i) |=> !act_q)
		else $error("inactive edge was delayed");
	a_db_cancel: assert property (
		(en_i && !act_q && $fell(sched_i)) |=> (cnt_q == '0) && !act_q)
		else $error("pending activation not cancelled");

endmodule // pds_deadband

// ==== logic/pds_shutdown_ctl.sv ====
// Shutdown status and restart sequencing
`timescale 1ns/1ps
module pds_shutdown_ctl
	import pds_pkg::*;
(
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic nrst_i,
	// Causes and restart policy
	input  wire logic cause_i,
	input  wire logic restart_en_i,
	input  wire logic period_start_i,
	// Software access to the status bit
	input  wire logic sw_wr_i,
	input  wire logic sw_val_i,
	// State
	output logic      status_o,
	output logic      run_o
);

	pds_sd_state_t state_q;
	pds_sd_state_t state_d;
	logic          set_c;
	logic          clr_c;

	// Writes are ignored while a cause is live; the cause itself sets the bit
	assign set_c = cause_i || (sw_wr_i && sw_val_i);
	assign clr_c = !cause_i && (restart_en_i || (sw_wr_i && !sw_val_i));

	always_comb begin
		state_d = state_q;
		case (state_q)
			PDS_SD_RUN: begin
				if (set_c) state_d = PDS_SD_TRIPPED;
			end
			PDS_SD_TRIPPED: begin
				if (!set_c && clr_c) state_d = PDS_SD_WAIT;
			end
			PDS_SD_WAIT: begin
				if (set_c) state_d = PDS_SD_TRIPPED;
				else if (period_start_i) state_d = PDS_SD_RUN;
			end
			default: state_d = PDS_SD_TRIPPED;
		endcase
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= PDS_SD_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	assign status_o = (state_q == PDS_SD_TRIPPED);
	assign run_o    = (state_q == PDS_SD_RUN);

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	a_status_sets: assert property (
		cause_i |=> status_o)
		else $error("status bit not set by cause");
	a_write_ignored: assert property (
		(cause_i && sw_wr_i && !sw_val_i) |=> status_o)
		else $error("status cleared while cause active");
	a_resume_boundary: assert property (
		$rose(run_o) |-> $past(period_start_i) && !$past(status_o))
		else $error("resumed away from period start");
	a_cmp_level_holds: assert property (
		(status_o && cause_i) [*2] |-> status_o)
		else $error("status dropped while cause persists");

endmodule // pds_shutdown_ctl

// ==== dv/pds_bridge_drivers.sv ====
// Far-side switch drivers: resolve each bridge pin against its pull-down
`timescale 1ns/1ps
module pds_bridge_drivers
	import pds_pkg::*;
(
	// Pins from the bridge stage
	input  wire pds_quad_t pin_i,
	input  wire pds_quad_t oe_i,
	// Gate levels seen by the switches
	output pds_quad_t      gate_o
);
	// Released pins fall to the pull-down so the switch stays off
	assign gate_o = pin_i & oe_i;
endmodule // pds_bridge_drivers

// ==== dv/test_pds_pwm_bridge.sv ====
// Testbench for the dead-band and auto-shutdown bridge stage
`timescale 1ns/1ps
module test_pds_pwm_bridge
	import pds_pkg::*;
;
	logic        clock_i = 1'b0;
	logic        nrst_i;
	logic [1:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic        sched;
	logic        pstart;
	logic        flt_n;
	logic        cmp1;
	logic        cmp2;
	logic [7:0]  rdata;
	pds_quad_t   pins;
	pds_quad_t   oe;
	pds_quad_t   gate;
	logic        ptf;
	logic        rd_pend = 1'b0;
	logic [15:0] mon_e;
	logic [15:0] q_rd[$];
	logic [15:0] q_pin[$];
	logic [7:0]  q_flag[$];
	int          num_errors = 0;
	int          samples_checked = 0;
	int          seed = 37;
	int          i;
	int          s;
	int          c;
	logic        b;
	logic        hit;

	pds_pwm_bridge #(.ENHANCED(1'b1)) i_pds_pwm_bridge (
		.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pwm_sched_i(sched),
		.period_start_i(pstart), .fault_in_n_i(flt_n), .cmp1_i(cmp1),
		.cmp2_i(cmp2), .bridge_o(pins), .bridge_oe_o(oe),
		.period_timer_flag_o(ptf)
	);

	pds_bridge_drivers i_pds_bridge_drivers (.pin_i(pins), .oe_i(oe), .gate_o(gate));

	always #25 clock_i = ~clock_i;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
		q_rd.push_back({e, 8'hff});
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		@(posedge clock_i);
	endtask

	// Expected {enables, levels} under a mask, judged at the next falling edge
	task automatic pin(input logic [7:0] e, input logic [7:0] m);
		q_pin.push_back({e, m});
		@(posedge clock_i);
	endtask

	// Expected period flag, judged at the next falling edge
	task automatic flag(input logic [7:0] e);
		q_flag.push_back(e);
		@(posedge clock_i);
	endtask

	task automatic tick();
		pstart <= 1'b1;
		@(posedge clock_i);
		pstart <= 1'b0;
		@(posedge clock_i);
	endtask

	// Falling edge keeps the sample clear of the launching edge
	always @(posedge clock_i) rd_pend <= rd;
	always @(negedge clock_i) begin
		if (rd_pend && q_rd.size() > 0) begin
			mon_e = q_rd.pop_front();
			check(rdata & mon_e[7:0], mon_e[15:8]);
		end
		if (q_pin.size() > 0) begin
			mon_e = q_pin.pop_front();
			check({oe, gate} & mon_e[7:0], mon_e[15:8]);
		end
		if (q_flag.size() > 0) begin
			mon_e = {8'h00, q_flag.pop_front()};
			check({7'h00, ptf}, mon_e[7:0]);
		end
	end

	initial begin
		repeat (20000) @(posedge clock_i);
		num_errors++;
		results();
	end

	initial begin
		{addr, wdata, wr, rd, sched, pstart, cmp1, cmp2} = '0;
		flt_n = 1'b1;
		nrst_i = 1'b0;
		cyc(2);
		nrst_i <= 1'b1;
		cyc(1);
		pin(8'h00, 8'hff);
		for (i = 0; i < 4; i++) rd_reg(2'(i), 8'h00);
		repeat (4) begin
			wdata <= 8'($random(seed));
			cyc(1);
			wr_reg(PDS_OFS_CFG, wdata);
			rd_reg(PDS_OFS_CFG, wdata);
		end
		wr_reg(PDS_OFS_MODE, 8'hff);
		rd_reg(PDS_OFS_MODE, PDS_MODE_MASK);
		// Half bridge, count 5
		wr_reg(PDS_OFS_CFG, 8'h05);
		wr_reg(PDS_OFS_MODE, 8'h14);
		cyc(8);
		pin(8'hc4, 8'hcc);
		sched <= 1'b1;
		cyc(2);
		pin(8'hc0, 8'hcc);
		cyc(2);
		pin(8'hc0, 8'hcc);
		cyc(2);
		pin(8'hc8, 8'hcc);
		sched <= 1'b0;
		cyc(2);
		pin(8'hc0, 8'hcc);
		cyc(8);
		pin(8'hc4, 8'hcc);
		sched <= 1'b1;
		cyc(2);
		repeat (2) pin(8'hc0, 8'hcc);
		sched <= 1'b0;
		repeat (6) pin(8'hc0, 8'hcc);
		cyc(8);
		// Full forward: no dead band, random schedule
		wr_reg(PDS_OFS_MODE, 8'h18);
		repeat (20) begin
			b = 1'($random(seed));
			sched <= b;
			cyc(2);
			pin({7'h4c, b}, 8'h99);
		end
		sched <= 1'b0;
		cyc(2);
		// Every source code against every cause, auto restart on
		wr_reg(PDS_OFS_ASD, 8'h00);
		wr_reg(PDS_OFS_CFG, 8'h85);
		for (s = 0; s < 8; s++) begin
			for (c = 0; c < 3; c++) begin
				wr_reg(PDS_OFS_ASD, {1'b0, 3'(s), 4'h1});
				hit = s[c];
				cmp1 <= (c == 0);
				cmp2 <= (c == 1);
				flt_n <= (c != 2);
				pin(hit ? 8'hf5 : 8'h98, hit ? 8'hff : 8'h99);
				rd_reg(PDS_OFS_ASD, {hit, 3'(s), 4'h1});
				cmp1 <= 1'b0;
				cmp2 <= 1'b0;
				flt_n <= 1'b1;
				cyc(2);
				rd_reg(PDS_OFS_ASD, {1'b0, 3'(s), 4'h1});
				if (hit) pin(8'hf5, 8'hff);
				tick();
				pin(8'h98, 8'h99);
			end
		end
		// Manual restart with the fault pin
		wr_reg(PDS_OFS_CFG, 8'h05);
		wr_reg(PDS_OFS_ASD, 8'h41);
		flt_n <= 1'b0;
		cyc(1);
		wr_reg(PDS_OFS_ASD, 8'h41);
		rd_reg(PDS_OFS_ASD, 8'hc1);
		flt_n <= 1'b1;
		cyc(2);
		rd_reg(PDS_OFS_ASD, 8'hc1);
		tick();
		pin(8'hf5, 8'hff);
		wr_reg(PDS_OFS_ASD, 8'h41);
		pin(8'hf5, 8'hff);
		rd_reg(PDS_OFS_ASD, 8'h41);
		tick();
		pin(8'h98, 8'h99);
		// Software trip with released pairs
		wr_reg(PDS_OFS_ASD, 8'h8b);
		pin(8'h00, 8'hff);
		rd_reg(PDS_OFS_ASD, 8'h8b);
		wr_reg(PDS_OFS_ASD, 8'h0b);
		tick();
		// Full reverse: C held, B follows the schedule undelayed
		wr_reg(PDS_OFS_MODE, 8'h1c);
		sched <= 1'b1;
		cyc(2);
		pin(8'hf6, 8'hff);
		sched <= 1'b0;
		cyc(2);
		// Polarity per pair, set while disabled; shutdown levels stay absolute
		wr_reg(PDS_OFS_MODE, 8'h0a);
		wr_reg(PDS_OFS_MODE, 8'h1a);
		cyc(4);
		pin(8'h90, 8'h99);
		wr_reg(PDS_OFS_MODE, 8'h0b);
		wr_reg(PDS_OFS_MODE, 8'h1b);
		cyc(4);
		pin(8'h91, 8'h99);
		wr_reg(PDS_OFS_ASD, 8'h84);
		pin(8'hfa, 8'hff);
		wr_reg(PDS_OFS_ASD, 8'h04);
		tick();
		rd_reg(PDS_OFS_STAT, 8'h01);
		flag(8'h01);
		wr_reg(PDS_OFS_STAT, 8'h00);
		rd_reg(PDS_OFS_STAT, 8'h00);
		flag(8'h00);
		cyc(3);
		results();
	end
endmodule // test_pds_pwm_bridge
